// ==== design/btbe_pkg.sv ====
package btbe_pkg;
    localparam logic [4:0] CodeTaken    = 5'h05;
    localparam logic [4:0] CodeData1    = 5'h08;
    localparam logic [4:0] CodeData2    = 5'h09;
    localparam logic [4:0] CodeData4    = 5'h0B;
    localparam logic [4:0] CodeAddr2    = 5'h0D;
    localparam logic [4:0] CodeAddr3    = 5'h0E;
    localparam logic [4:0] CodeExcept   = 5'h1C;
    localparam logic [1:0] AddrPrefix   = 2'h2;
    localparam logic [1:0] CfgAddrNone  = 2'h0;
    localparam logic [1:0] CfgAddr2     = 2'h1;
    localparam logic [1:0] CfgAddr3     = 2'h2;
    localparam int         CfgTgtLo     = 8;
    localparam logic [2:0] Nibbles2     = 3'h4;
    localparam logic [2:0] Nibbles3     = 3'h6;
    localparam logic [1:0] ExceptMax    = 2'h2;
    localparam int         EntryWidth   = 6;
    localparam int         BufDepth     = 64;
    localparam int         BufAddrWidth = 6;

    typedef struct packed {
        logic        valid;
        logic        takenBranch;
        logic        variantAddr;
        logic [23:0] target;
        logic        simpleStatus;
        logic [4:0]  statusCode;
        logic        exceptMode;
        logic [1:0]  dataBytes;
        logic        dataWrite;
        logic [31:0] dataValue;
    } btbe_retire_t;
endpackage : btbe_pkg

// ==== design/btbe_trace_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module btbe_trace_store (
    input  wire logic                           core_clk,
    input  wire logic                           reset,
    input  wire logic                           writeEn,
    input  wire logic [btbe_pkg::EntryWidth-1:0] writeEntry,
    input  wire logic [btbe_pkg::BufAddrWidth-1:0] readAddr,
    output logic      [btbe_pkg::EntryWidth-1:0] readEntry,
    output logic      [btbe_pkg::BufAddrWidth-1:0] writePtr
);
    logic [btbe_pkg::EntryWidth-1:0]   mem [btbe_pkg::BufDepth];
    logic [btbe_pkg::BufAddrWidth-1:0] ptr_reg;
    logic [btbe_pkg::BufAddrWidth-1:0] ptr_next;

    always_comb begin
        ptr_next = ptr_reg;
        if (writeEn) begin
            ptr_next = ptr_reg + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ptr_reg <= '0;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (writeEn) begin
            mem[ptr_reg] <= writeEntry;
        end
        readEntry <= mem[readAddr];
    end

    assign writePtr = ptr_reg;
endmodule : btbe_trace_store
`default_nettype wire

// ==== design/btbe_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module btbe_encoder (
    input  wire logic                              core_clk,
    input  wire logic                              reset,
    input  wire btbe_pkg::btbe_retire_t            retire,
    output logic                                   retireReady,
    input  wire logic [31:0]                       debugConfig,
    input  wire logic [btbe_pkg::BufAddrWidth-1:0] readAddr,
    output logic      [btbe_pkg::EntryWidth-1:0]   readEntry,
    output logic      [btbe_pkg::BufAddrWidth-1:0] writePtr
);
    typedef enum logic [2:0] {StIdle, StMarker, StAddr, StDataHdr, StData} btbe_state_t;

    btbe_state_t  state_reg, state_next;
    logic [23:0]  addr_reg, addr_next;
    logic [2:0]   nibLeft_reg, nibLeft_next;
    logic [4:0]   marker_reg, marker_next;
    logic [31:0]  data_reg, data_next;
    logic [3:0]   dataLeft_reg, dataLeft_next;
    logic [4:0]   dataCode_reg, dataCode_next;
    logic         dataWr_reg, dataWr_next;
    logic         dataPend_reg, dataPend_next;
    logic [1:0]   exCount_reg, exCount_next;

    logic         wrEn;
    logic [5:0]   wrEntry;
    logic [1:0]   tgtCountSel;
    logic         accept;
    logic         captureOn;
    logic         captureThree;
    logic         exceptWrite;

    assign tgtCountSel  = debugConfig[btbe_pkg::CfgTgtLo +: 2];
    assign retireReady  = (state_reg == StIdle);
    assign accept       = retire.valid && retireReady;
    // Setting 3 is reserved, so it reads as capture off
    assign captureThree = (tgtCountSel == btbe_pkg::CfgAddr3);
    assign captureOn    = retire.takenBranch && retire.variantAddr
                          && (tgtCountSel == btbe_pkg::CfgAddr2 || captureThree);
    assign exceptWrite  = (exCount_reg != btbe_pkg::ExceptMax);

    // Exception run counter
    always_comb begin
        exCount_next = exCount_reg;
        if (accept) begin
            if (!retire.exceptMode) begin
                exCount_next = 2'h0;
            end else if (exceptWrite) begin
                exCount_next = exCount_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            exCount_reg <= '0;
        end else begin
            exCount_reg <= exCount_next;
        end
    end

    // Operand data descriptor
    always_comb begin
        data_next     = data_reg;
        dataLeft_next = dataLeft_reg;
        dataCode_next = dataCode_reg;
        dataWr_next   = dataWr_reg;
        dataPend_next = dataPend_reg;
        if (accept) begin
            // Latched up front, as data rides behind any address nibbles
            data_next     = retire.dataValue;
            dataWr_next   = retire.dataWrite;
            dataPend_next = (retire.dataBytes != 2'h0) && !retire.exceptMode;
            case (retire.dataBytes)
                2'h1: begin
                    dataCode_next = btbe_pkg::CodeData1;
                    dataLeft_next = 4'h2;
                end
                2'h2: begin
                    dataCode_next = btbe_pkg::CodeData2;
                    dataLeft_next = 4'h4;
                end
                default: begin
                    dataCode_next = btbe_pkg::CodeData4;
                    dataLeft_next = 4'h8;
                end
            endcase
        end else if (state_reg == StData) begin
            data_next     = {4'h0, data_reg[31:4]};
            dataLeft_next = dataLeft_reg - 4'h1;
            if (dataLeft_reg == 4'h1) begin
                dataPend_next = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_reg     <= '0;
            dataLeft_reg <= '0;
            dataCode_reg <= '0;
            dataWr_reg   <= 1'b0;
            dataPend_reg <= 1'b0;
        end else begin
            data_reg     <= data_next;
            dataLeft_reg <= dataLeft_next;
            dataCode_reg <= dataCode_next;
            dataWr_reg   <= dataWr_next;
            dataPend_reg <= dataPend_next;
        end
    end

    // Branch entry sequencer

    always_comb begin
        state_next   = state_reg;
        addr_next    = addr_reg;
        nibLeft_next = nibLeft_reg;
        marker_next  = marker_reg;
        wrEn         = 1'b0;
        wrEntry      = 6'h00;
        case (state_reg)
            StIdle: begin
                if (accept && retire.exceptMode) begin
                    // Long exception modes would flood the buffer, so two are kept
                    wrEn    = exceptWrite;
                    wrEntry = {1'b0, btbe_pkg::CodeExcept};
                end else if (accept) begin
                    wrEn = 1'b1;
                    if (retire.takenBranch) begin
                        wrEntry = {1'b0, btbe_pkg::CodeTaken};
                    end else begin
                        wrEntry = {1'b0, retire.statusCode};
                    end
                    // Shift right by one drops bit 0 of the target
                    addr_next = {1'b0, retire.target[23:1]};
                    if (captureOn) begin
                        state_next = StMarker;
                        if (captureThree) begin
                            marker_next  = btbe_pkg::CodeAddr3;
                            nibLeft_next = btbe_pkg::Nibbles3;
                        end else begin
                            marker_next  = btbe_pkg::CodeAddr2;
                            nibLeft_next = btbe_pkg::Nibbles2;
                        end
                    end else if (dataPend_next) begin
                        state_next = StDataHdr;
                    end
                end
            end
            StMarker: begin
                wrEn       = 1'b1;
                wrEntry    = {1'b0, marker_reg};
                state_next = StAddr;
            end
            StAddr: begin
                wrEn         = 1'b1;
                wrEntry      = {btbe_pkg::AddrPrefix, addr_reg[3:0]};
                addr_next    = {4'h0, addr_reg[23:4]};
                nibLeft_next = nibLeft_reg - 3'h1;
                if (nibLeft_reg == 3'h1) begin
                    state_next = dataPend_reg ? StDataHdr : StIdle;
                end
            end
            StDataHdr: begin
                wrEn       = 1'b1;
                wrEntry    = {1'b0, dataCode_reg};
                state_next = StData;
            end
            StData: begin
                wrEn    = 1'b1;
                wrEntry = {1'b1, dataWr_reg, data_reg[3:0]};
                if (dataLeft_reg == 4'h1) begin
                    state_next = StIdle;
                end
            end
            default: begin
                state_next = StIdle;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg   <= StIdle;
            addr_reg    <= '0;
            nibLeft_reg <= '0;
            marker_reg  <= '0;
        end else begin
            state_reg   <= state_next;
            addr_reg    <= addr_next;
            nibLeft_reg <= nibLeft_next;
            marker_reg  <= marker_next;
        end
    end

    // Buffer contents survive reset; only the pointer restarts
    btbe_trace_store u_store (
        .core_clk   (core_clk),
        .reset      (reset),
        .writeEn    (wrEn),
        .writeEntry (wrEntry),
        .readAddr   (readAddr),
        .readEntry  (readEntry),
        .writePtr   (writePtr)
    );
endmodule : btbe_encoder
`default_nettype wire

// ==== test/btbe_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module btbe_core_model (
    input  wire logic             core_clk,
    input  wire logic             retireReady,
    output btbe_pkg::btbe_retire_t retire
);
    initial retire = '0;
    task automatic send(input btbe_pkg::btbe_retire_t r);
        @(negedge core_clk);
        retire = r;
        // Held until taken, like a stalled pipeline
        while (retireReady !== 1'h1) @(negedge core_clk);
        @(posedge core_clk);
    endtask : send
    task automatic idle();
        @(negedge core_clk);
        retire = {1'h0, ~retire[67:0]}; // Junk payload, so stale data never passes
    endtask : idle
endmodule : btbe_core_model
`default_nettype wire

// ==== test/btbe_encoder_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module btbe_encoder_monitor (
    input wire logic                               core_clk,
    input wire logic                               reset,
    input wire btbe_pkg::btbe_retire_t             retire,
    input wire logic                               retireReady,
    input wire logic [31:0]                        debugConfig,
    input wire logic [btbe_pkg::BufAddrWidth-1:0] writePtr
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    logic       acc;
    logic [1:0] run_reg;
    logic [1:0] run_next;
    assign acc = retire.valid && retireReady;
    always_comb begin
        run_next = run_reg;
        if (acc) begin
            run_next = !retire.exceptMode ? 2'h0 : (run_reg == 2'h2 ? 2'h2 : run_reg + 2'h1);
        end
    end
    always_ff @(posedge core_clk) begin
        run_reg <= reset ? 2'h0 : run_next;
    end
    chk_reset_state: assert property ($fell(reset) |-> retireReady && writePtr == 6'h00)
        else $error("bad state after reset");
    chk_ptr_step: assert property (!$past(reset)
        |-> (writePtr - $past(writePtr)) <= 6'h01)
        else $error("write pointer jumped");
    chk_taken_entry: assert property (acc && retire.takenBranch && !retire.exceptMode
        |=> writePtr == $past(writePtr) + 6'h01)
        else $error("taken branch wrote no entry");
    chk_addr2_len: assert property (acc && retire.takenBranch && retire.variantAddr
        && !retire.exceptMode && debugConfig[9:8] == 2'h1 && retire.dataBytes == 2'h0
        |=> !retireReady[*5] ##1 retireReady)
        else $error("two byte capture length wrong");
    chk_addr3_len: assert property (acc && retire.takenBranch && retire.variantAddr
        && !retire.exceptMode && debugConfig[9:8] == 2'h2 && retire.dataBytes == 2'h0
        |=> !retireReady[*7] ##1 retireReady)
        else $error("three byte capture length wrong");
    chk_no_capture: assert property (acc && retire.takenBranch && !retire.exceptMode
        && retire.dataBytes == 2'h0
        && (!retire.variantAddr || debugConfig[9:8] == 2'h0 || debugConfig[9:8] == 2'h3)
        |=> retireReady && writePtr == $past(writePtr) + 6'h01)
        else $error("extra entries without capture");
    chk_data4_len: assert property (acc && !retire.takenBranch && !retire.exceptMode
        && retire.dataBytes == 2'h3 |=> !retireReady[*8] ##1 !retireReady ##1 retireReady)
        else $error("four byte data length wrong");
    chk_except_drop: assert property (acc && retire.exceptMode && run_reg == 2'h2
        |=> writePtr == $past(writePtr))
        else $error("exception code not suppressed");
endmodule : btbe_encoder_monitor
bind btbe_encoder btbe_encoder_monitor mon (.core_clk(core_clk), .reset(reset), .retire(retire),
    .retireReady(retireReady), .debugConfig(debugConfig), .writePtr(writePtr));
`default_nettype wire

// ==== test/test_branch_trace_buffer_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_branch_trace_buffer_encoder;
    localparam logic [23:0] Tgt = 24'hA5B3C6;
    localparam logic [31:0] Val = 32'h8765_4321;
    logic        core_clk = 1'h0;
    logic        reset = 1'h1;
    logic [31:0] debugConfig = 32'h0000_0000;
    logic [5:0]  readAddr = 6'h00;
    logic [5:0]  readEntry;
    logic [5:0]  writePtr;
    logic [5:0]  base = 6'h00;
    logic [5:0]  exp[$];
    logic        retireReady;
    int          fails = 0;
    int          checked = 0;
    btbe_pkg::btbe_retire_t retire;
    btbe_core_model core (.core_clk(core_clk), .retireReady(retireReady), .retire(retire));
    btbe_encoder dut (.core_clk(core_clk), .reset(reset), .retire(retire),
        .retireReady(retireReady), .debugConfig(debugConfig), .readAddr(readAddr),
        .readEntry(readEntry), .writePtr(writePtr));
    function automatic btbe_pkg::btbe_retire_t rec(logic tk, logic va, logic [4:0] sc, logic ex,
        logic [1:0] db);
        return '{valid: 1'h1, takenBranch: tk, variantAddr: va, target: Tgt, statusCode: sc,
            exceptMode: ex, dataBytes: db, dataWrite: 1'h1, dataValue: Val, default: '0};
    endfunction : rec
    task automatic chk(input logic [5:0] seen, input logic [5:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task automatic nib(input logic [31:0] v, input int n, input logic [1:0] pre);
        for (int i = 0; i < n; i++) exp.push_back({pre, v[4*i +: 4]});
    endtask : nib
    task automatic verify();
        core.idle();
        for (int n = 0; n < 40 && retireReady !== 1'h1; n++) @(negedge core_clk);
        if (retireReady !== 1'h1) fails++;
        @(negedge core_clk);
        chk(writePtr, base + 6'(exp.size()));
        foreach (exp[i]) begin
            readAddr = base + 6'(i);
            @(negedge core_clk);
            chk(readEntry, exp[i]);
        end
        base = writePtr;
        exp.delete();
    endtask : verify
    task automatic test_addr2();
        debugConfig = 32'h0000_0100;
        core.send(rec(1'h1, 1'h1, 5'h00, 1'h0, 2'h0));
        exp = '{{1'h0, btbe_pkg::CodeTaken}, {1'h0, btbe_pkg::CodeAddr2}};
        nib({8'h00, Tgt >> 1}, 4, 2'h2);
        verify();
    endtask : test_addr2
    task automatic test_addr3();
        debugConfig = 32'h0000_0200;
        core.send(rec(1'h1, 1'h1, 5'h00, 1'h0, 2'h0));
        exp = '{{1'h0, btbe_pkg::CodeTaken}, {1'h0, btbe_pkg::CodeAddr3}};
        nib({8'h00, Tgt >> 1}, 6, 2'h2);
        verify();
    endtask : test_addr3
    task automatic test_nocap();
        logic [31:0] cfg[3] = '{32'h0000_0000, 32'h0000_0300, 32'h0000_0100};
        for (int k = 0; k < 3; k++) begin
            debugConfig = cfg[k];
            core.send(rec(1'h1, 1'(k < 2), 5'h00, 1'h0, 2'h0));
            core.send(rec(1'h0, 1'h0, 5'h01, 1'h0, 2'h0));
            exp = '{{1'h0, btbe_pkg::CodeTaken}, 6'h01};
            verify();
        end
    endtask : test_nocap
    task automatic test_data();
        logic [4:0] hdr[3] = '{btbe_pkg::CodeData1, btbe_pkg::CodeData2, btbe_pkg::CodeData4};
        btbe_pkg::btbe_retire_t r;
        debugConfig = 32'h0000_0000;
        for (int k = 0; k < 3; k++) begin
            r = rec(1'h0, 1'h0, 5'h01, 1'h0, 2'(k + 1));
            r.dataWrite = 1'(k != 1); // Middle value is a read
            core.send(r);
            exp.push_back(6'h01);
            exp.push_back({1'h0, hdr[k]});
            nib(Val, 2 << k, {1'h1, r.dataWrite});
        end
        verify();
    endtask : test_data
    task automatic test_except();
        repeat (3) core.send(rec(1'h0, 1'h0, btbe_pkg::CodeExcept, 1'h1, 2'h0));
        core.send(rec(1'h0, 1'h0, 5'h01, 1'h0, 2'h0));
        exp = '{{1'h0, btbe_pkg::CodeExcept}, {1'h0, btbe_pkg::CodeExcept}, 6'h01};
        verify();
    endtask : test_except
    task automatic end_of_test();
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    initial forever #2 core_clk = ~core_clk;
    initial begin
        #20000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (5) @(negedge core_clk);
        reset = 1'h0;
        test_addr2();
        test_addr3();
        test_nocap();
        test_data();
        test_except();
        end_of_test();
    end
endmodule : test_branch_trace_buffer_encoder
`default_nettype wire
